// ---- pps_cfg.svh ----
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
// -----------------------------------------------------------
// register map
// -----------------------------------------------------------
`define PPS_OFS_DIR   3'h0
`define PPS_OFS_OUT   3'h1
`define PPS_OFS_PIN   3'h2
`define PPS_OFS_MCU   3'h3
`define PPS_OFS_FLAG  3'h4
// -----------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------
`define PPS_PULLOFF_BIT 4
`define PPS_MCU_RW_MASK 8'h13
`define PPS_RST_BYTE    8'h00
`define PPS_RST_LOW2    2'h0
// -----------------------------------------------------------
// interrupt sense codes, two bits per pin
// -----------------------------------------------------------
`define PPS_SENSE_NONE 2'h0
`define PPS_SENSE_ANY  2'h1
`define PPS_SENSE_FALL 2'h2
`define PPS_SENSE_RISE 2'h3
`endif

// ---- pps_pkg.sv ----
package pps_pkg;
  typedef logic [7:0]  pps_byte_type;
  typedef logic [2:0]  pps_addr_type;
  typedef logic [15:0] pps_sense_type;
  typedef struct packed {
    pps_byte_type dir_bit;
    pps_byte_type out_latch_bit;
    logic         global_pullup_off;
    logic [1:0]   mcu_low;
    pps_byte_type sync_q;
    pps_byte_type prev_q;
    pps_byte_type int_flag;
    pps_byte_type rdata;
  } pps_state_type;
endpackage

// ---- pps_port.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pps_cfg.svh"
module pps_port (
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire pps_pkg::pps_addr_type addr,
  input  wire pps_pkg::pps_byte_type wdata,
  input  wire logic           port_write_strobe,
  input  wire logic           port_read_strobe,
  output var  pps_pkg::pps_byte_type rdata,
  input  wire logic           sleep_active,
  input  wire pps_pkg::pps_byte_type ext_int_en,
  input  wire pps_pkg::pps_sense_type int_sense,
  output var  pps_pkg::pps_byte_type ext_int_flag,
  input  wire pps_pkg::pps_byte_type pullup_ovr_en,
  input  wire pps_pkg::pps_byte_type pullup_ovr_val,
  input  wire pps_pkg::pps_byte_type drv_ovr_en,
  input  wire pps_pkg::pps_byte_type drv_ovr_val,
  input  wire pps_pkg::pps_byte_type value_ovr_en,
  input  wire pps_pkg::pps_byte_type value_ovr_val,
  input  wire pps_pkg::pps_byte_type toggle_ovr_en,
  input  wire pps_pkg::pps_byte_type in_enable_ovr_en,
  input  wire pps_pkg::pps_byte_type in_enable_ovr_val,
  input  wire pps_pkg::pps_byte_type pad_in,
  output var  pps_pkg::pps_byte_type pad_out,
  output var  pps_pkg::pps_byte_type pad_oe,
  output var  pps_pkg::pps_byte_type pullup_on,
  output var  pps_pkg::pps_byte_type alt_raw_input,
  output var  pps_pkg::pps_byte_type analog_pad_link,
  output logic [1:0]          mcu_ctrl_low
);
  import pps_pkg::*;

  // -----------------------------------------------------------
  // state
  // -----------------------------------------------------------
  pps_state_type st;
  pps_state_type next_st;
  pps_byte_type  die;
  pps_byte_type  sync_latch;
  pps_byte_type  rise;
  pps_byte_type  fall;
  pps_byte_type  event_hit;
  pps_byte_type  wr_mcu_val;
  logic          wr_dir;
  logic          wr_out;
  logic          wr_pin;
  logic          wr_mcu;
  logic          wr_flag;

  assign wr_dir  = port_write_strobe && (addr == `PPS_OFS_DIR);
  assign wr_out  = port_write_strobe && (addr == `PPS_OFS_OUT);
  assign wr_pin  = port_write_strobe && (addr == `PPS_OFS_PIN);
  assign wr_mcu  = port_write_strobe && (addr == `PPS_OFS_MCU);
  assign wr_flag = port_write_strobe && (addr == `PPS_OFS_FLAG);

  // -----------------------------------------------------------
  // input path
  // -----------------------------------------------------------
  // every override input is a per-pin vector; sleep, clock and
  // the pull-up off bit are single and common to all pins
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (in_enable_ovr_en[n]) begin
        die[n] = in_enable_ovr_val[n];
      end else begin
        die[n] = !(sleep_active && !ext_int_en[n]);
      end
    end
  end

  // clamped input taken before the synchroniser; a receiver
  // that does not use it as a clock must resync it itself
  assign alt_raw_input = pad_in & die;

  // the true analogue joint sits in the pad wrapper; this is
  // the unbuffered pad level handed straight through
  assign analog_pad_link = pad_in;

  // low-phase stage stands in for the transparent latch, so an
  // edge reaches the read bit after half to one and a half cycles
  always_ff @(negedge clk_sys) begin
    sync_latch <= alt_raw_input;
  end

  // -----------------------------------------------------------
  // interrupt edge detect on the clamped, synchronised input
  // -----------------------------------------------------------
  assign rise = st.sync_q & ~st.prev_q;
  assign fall = ~st.sync_q & st.prev_q;

  // clamp release with pin high is a real rising edge here,
  // so the flag sets on wake even when the request is masked
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      case (int_sense[2*n +: 2])
        `PPS_SENSE_ANY:  event_hit[n] = rise[n] | fall[n];
        `PPS_SENSE_FALL: event_hit[n] = fall[n];
        `PPS_SENSE_RISE: event_hit[n] = rise[n];
        default:         event_hit[n] = 1'b0;
      endcase
    end
  end

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------
  assign wr_mcu_val = wdata & `PPS_MCU_RW_MASK;

  always_comb begin
    next_st = st;
    next_st.sync_q = sync_latch;
    next_st.prev_q = st.sync_q;
    if (wr_dir) begin
      next_st.dir_bit = wdata;
    end
    if (wr_out) begin
      next_st.out_latch_bit = wdata;
    end
    // both toggle sources act on top of a plain write
    if (wr_pin) begin
      next_st.out_latch_bit = next_st.out_latch_bit ^ wdata;
    end
    next_st.out_latch_bit = next_st.out_latch_bit ^ toggle_ovr_en;
    if (wr_mcu) begin
      next_st.global_pullup_off = wr_mcu_val[`PPS_PULLOFF_BIT];
      next_st.mcu_low = wr_mcu_val[1:0];
    end
    // write one to clear; a new event in the same cycle wins
    if (wr_flag) begin
      next_st.int_flag = st.int_flag & ~wdata;
    end
    next_st.int_flag = next_st.int_flag | event_hit;
    next_st.rdata = `PPS_RST_BYTE;
    if (port_read_strobe) begin
      case (addr)
        `PPS_OFS_DIR:  next_st.rdata = st.dir_bit;
        `PPS_OFS_OUT:  next_st.rdata = st.out_latch_bit;
        `PPS_OFS_PIN:  next_st.rdata = st.sync_q;
        `PPS_OFS_MCU:  next_st.rdata = {3'h0, st.global_pullup_off,
                                        2'h0, st.mcu_low};
        `PPS_OFS_FLAG: next_st.rdata = st.int_flag;
        default:       next_st.rdata = `PPS_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st.dir_bit           <= `PPS_RST_BYTE;
      st.out_latch_bit     <= `PPS_RST_BYTE;
      st.global_pullup_off <= 1'b0;
      st.mcu_low           <= `PPS_RST_LOW2;
      st.sync_q            <= `PPS_RST_BYTE;
      st.prev_q            <= `PPS_RST_BYTE;
      st.int_flag          <= `PPS_RST_BYTE;
      st.rdata             <= `PPS_RST_BYTE;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------
  // pad drive and pull-up
  // -----------------------------------------------------------
  // reset gates drive and pull-up without waiting for a clock
  // edge, so pins float the moment reset goes low
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (drv_ovr_en[n]) begin
        pad_oe[n] = drv_ovr_val[n] && rst_n;
      end else begin
        pad_oe[n] = st.dir_bit[n] && rst_n;
      end
      if (value_ovr_en[n]) begin
        pad_out[n] = value_ovr_val[n];
      end else begin
        pad_out[n] = st.out_latch_bit[n];
      end
      if (pullup_ovr_en[n]) begin
        pullup_on[n] = pullup_ovr_val[n] && rst_n;
      end else begin
        // the simplest defined level for an idle pin
        pullup_on[n] = ({st.dir_bit[n], st.out_latch_bit[n],
                         st.global_pullup_off} == 3'h2)
                       && rst_n;
      end
    end
  end

  assign rdata        = st.rdata;
  assign ext_int_flag = st.int_flag;
  assign mcu_ctrl_low = st.mcu_low;

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_pull_normal: assert property (
    !pullup_ovr_en[0] && !st.dir_bit[0] && st.out_latch_bit[0]
      && !st.global_pullup_off |-> pullup_on[0])
    else $error("pull-up missing in input high state");

  a_pull_ovr: assert property (
    pullup_ovr_en[1] |-> pullup_on[1] == pullup_ovr_val[1])
    else $error("pull-up does not follow override value");

  a_pull_kill: assert property (
    st.global_pullup_off |-> (pullup_on & ~pullup_ovr_en) == 8'h00)
    else $error("pull-up on while global off bit set");

  a_drv_ovr: assert property (
    drv_ovr_en[2] |-> pad_oe[2] == drv_ovr_val[2])
    else $error("driver ignores override value");

  a_value_ovr: assert property (
    value_ovr_en[3] |-> pad_out[3] == value_ovr_val[3])
    else $error("pad value ignores override value");

  a_toggle_ovr: assert property (
    toggle_ovr_en[4] && !wr_out && !wr_pin
      |=> st.out_latch_bit[4] != $past(st.out_latch_bit[4]))
    else $error("toggle override did not invert latch");

  a_pin_toggle: assert property (
    wr_pin && wdata[5] && !toggle_ovr_en[5]
      |=> st.out_latch_bit[5] != $past(st.out_latch_bit[5]))
    else $error("write one to read bit did not toggle");

  a_sleep_clamp: assert property (
    sleep_active && !ext_int_en[6] && !in_enable_ovr_en[6]
      |-> !alt_raw_input[6])
    else $error("input not clamped in deep sleep");

  sequence s_settled;
    ($stable(pad_in) && $stable(die))[*3];
  endsequence
  a_sync_delay: assert property (
    s_settled |-> st.sync_q == (pad_in & die))
    else $error("read bit lags a settled input");

  sequence s_sleep_high;
    sleep_active && pad_in[7] && !ext_int_en[7] && !in_enable_ovr_en[7];
  endsequence
  sequence s_wake_high;
    !sleep_active && pad_in[7] && !in_enable_ovr_en[7]
      && int_sense[15:14] == `PPS_SENSE_RISE && !wr_flag;
  endsequence
  a_wake_flag: assert property (
    s_sleep_high ##1 s_wake_high[*2] |-> ##[0:2] st.int_flag[7])
    else $error("wake from clamp did not set flag");

  a_reserved_zero: assert property (
    port_read_strobe && addr == `PPS_OFS_MCU
      |=> rdata[7:5] == 3'h0 && rdata[3:2] == 2'h0)
    else $error("reserved control bits not zero");

  a_reset_float: assert property (disable iff (1'b0)
    !rst_n |-> pad_oe == 8'h00 && pullup_on == 8'h00)
    else $error("pin driven or pulled during reset");

  // -----------------------------------------------------------
  // register, pad, input path and interrupt assertions
  // -----------------------------------------------------------
  a_drv_dir: assert property (
    !drv_ovr_en[0] |-> pad_oe[0] == st.dir_bit[0])
    else $error("driver enable ignores direction bit");

  a_drv_off: assert property (
    drv_ovr_en[6] && !drv_ovr_val[6] |-> !pad_oe[6])
    else $error("driver on although override value low");

  a_value_latch: assert property (
    !value_ovr_en[0] |-> pad_out[0] == st.out_latch_bit[0])
    else $error("pad value ignores output latch");

  a_pull_dir_out: assert property (
    !pullup_ovr_en[3] && st.dir_bit[3] |-> !pullup_on[3])
    else $error("pull-up on for an output pin");

  a_in_ovr_val: assert property (
    in_enable_ovr_en[1] |-> alt_raw_input[1] == (pad_in[1] && in_enable_ovr_val[1]))
    else $error("input enable ignores override value");

  a_clamp_exempt: assert property (
    sleep_active && ext_int_en[0] && !in_enable_ovr_en[0]
      |-> alt_raw_input[0] == pad_in[0])
    else $error("interrupt pin clamped in deep sleep");

  a_awake_pass: assert property (
    !sleep_active && !in_enable_ovr_en[2] |-> alt_raw_input[2] == pad_in[2])
    else $error("input blocked while awake");

  a_analog_link: assert property (
    analog_pad_link == pad_in)
    else $error("analogue link differs from pad");

  a_write_dir: assert property (
    wr_dir |=> st.dir_bit == $past(wdata))
    else $error("direction write lost");

  a_write_out: assert property (
    wr_out && toggle_ovr_en == 8'h00 |=> st.out_latch_bit == $past(wdata))
    else $error("output latch write lost");

  a_mcu_write: assert property (
    wr_mcu |=> st.mcu_low == $past(wdata[1:0])
      && st.global_pullup_off == $past(wdata[4]))
    else $error("control write lost");

  a_pin_read: assert property (
    port_read_strobe && addr == `PPS_OFS_PIN |=> rdata == $past(st.sync_q))
    else $error("read bit not returned");

  // rdata is zero outside the answer cycle so that a bus OR stays clean
  a_rdata_idle: assert property (
    rst_n && !port_read_strobe |=> rdata == 8'h00)
    else $error("read data stands without a read");

  a_read_none: assert property (
    port_read_strobe && addr > `PPS_OFS_FLAG |=> rdata == 8'h00)
    else $error("unmapped index reads non zero");

  a_flag_set: assert property (
    event_hit[2] |=> st.int_flag[2])
    else $error("edge event did not set flag");

  a_flag_clear: assert property (
    wr_flag && wdata[3] && !event_hit[3] |=> !st.int_flag[3])
    else $error("flag not cleared by write one");

  a_sense_none: assert property (
    int_sense[1:0] == `PPS_SENSE_NONE |-> !event_hit[0])
    else $error("event on a pin with no sense");

  a_rise_event: assert property (
    int_sense[5:4] == `PPS_SENSE_RISE && rise[2] |-> event_hit[2])
    else $error("rising edge missed");

  a_fall_event: assert property (
    int_sense[9:8] == `PPS_SENSE_FALL && fall[4] |-> event_hit[4])
    else $error("falling edge missed");

  // gated by rst_n so the edge that leaves reset is not judged
  a_sync_step: assert property (
    rst_n |=> st.sync_q == $past(sync_latch))
    else $error("read bit skipped the latch stage");

  sequence s_sleep_any;
    sleep_active && pad_in[3] && !ext_int_en[3] && !in_enable_ovr_en[3];
  endsequence
  sequence s_wake_any;
    !sleep_active && pad_in[3] && !in_enable_ovr_en[3]
      && int_sense[7:6] == `PPS_SENSE_ANY && !wr_flag;
  endsequence
  a_wake_any: assert property (
    s_sleep_any ##1 s_wake_any[*2] |-> ##[0:2] st.int_flag[3])
    else $error("wake with any change did not set flag");

  a_reset_regs: assert property (disable iff (1'b0)
    !rst_n |=> st.dir_bit == 8'h00 && st.out_latch_bit == 8'h00
      && st.int_flag == 8'h00)
    else $error("registers not cleared by reset");

endmodule // pps_port
`default_nettype wire

// ---- pps_board_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// board side of the pads: external drivers and pull-ups
// ------------------------------------------------------------
module pps_board_model (
  input  wire logic                  clk_sys,
  input  wire pps_pkg::pps_byte_type pad_out,
  input  wire pps_pkg::pps_byte_type pad_oe,
  input  wire pps_pkg::pps_byte_type pullup_on,
  input  wire pps_pkg::pps_byte_type ext_en,
  input  wire pps_pkg::pps_byte_type ext_val,
  output var  pps_pkg::pps_byte_type pad_in
);
  import pps_pkg::*;
  // a floating pad wanders, so a stale level never passes for a real one
  pps_byte_type float_q = 8'h5a;
  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pullup_on[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = float_q[i];
      end
    end
  end
endmodule // pps_board_model
`default_nettype wire

// ---- pps_port_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module pps_port_tb_top;
  import pps_pkg::*;
  logic          clk_sys, rst_n, port_write_strobe, port_read_strobe, sleep_active;
  pps_addr_type  addr;
  pps_sense_type int_sense;
  pps_byte_type  wdata, rdata, ext_int_en, ext_int_flag, pullup_ovr_en, pullup_ovr_val;
  pps_byte_type  drv_ovr_en, drv_ovr_val, value_ovr_en, value_ovr_val, toggle_ovr_en;
  pps_byte_type  in_enable_ovr_en, in_enable_ovr_val, pad_in, pad_out, pad_oe, pullup_on;
  pps_byte_type  alt_raw_input, analog_pad_link, ext_en, ext_val;
  logic [1:0]    mcu_ctrl_low;
  int            n_errors = 0;
  int            compares = 0;
  pps_port i_pps_port (.*);
  pps_board_model i_pps_board_model (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe(pad_oe),
    .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  // ------------------------------------------------------------
  // bus tasks and checking
  // ------------------------------------------------------------
  task automatic check(input pps_byte_type seen, input pps_byte_type exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input pps_addr_type a, input pps_byte_type d);
    @(posedge clk_sys);
    port_write_strobe <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    port_write_strobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input pps_addr_type a, input pps_byte_type exp);
    @(posedge clk_sys);
    port_read_strobe <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    port_read_strobe <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_tristate;
    wr(3'h0, 8'h0f);
    wr(3'h1, 8'hf0);
    check(pad_oe, 8'h0f);
    @(posedge clk_sys) rst_n <= 1'b0;
    // registers still hold here, only the reset gate can clear the pins
    #1 check(pad_oe, 8'h00);
    check(pullup_on, 8'h00);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(3'h0, 8'h00);
  endtask
  task automatic t_regs;
    wr(3'h3, 8'hff);
    rd(3'h3, 8'h13);
    check({6'h0, mcu_ctrl_low}, 8'h03);
    wr(3'h3, 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
  endtask
  task automatic t_pullup;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hff);
    check(pullup_on, 8'hff);
    wr(3'h3, 8'h10);
    check(pullup_on, 8'h00);
    @(posedge clk_sys);
    pullup_ovr_en <= 8'h0f;
    pullup_ovr_val <= 8'h05;
    #1 check(pullup_on, 8'h05);
    wr(3'h3, 8'h00);
    check(pullup_on, 8'hf5);
    pullup_ovr_en <= 8'h00;
  endtask
  task automatic t_drive;
    wr(3'h0, 8'h0f);
    wr(3'h1, 8'h55);
    drv_ovr_en <= 8'hf4;
    drv_ovr_val <= 8'ha4;
    value_ovr_en <= 8'h0f;
    value_ovr_val <= 8'h0a;
    @(posedge clk_sys);
    #1 check(pad_oe, 8'haf);
    check(pad_out, 8'h5a);
    check(analog_pad_link, 8'h5a);
    drv_ovr_en <= 8'h00;
    value_ovr_en <= 8'h00;
  endtask
  task automatic t_toggle;
    wr(3'h2, 8'h2f);
    rd(3'h1, 8'h7a);
    @(posedge clk_sys) toggle_ovr_en <= 8'h91;
    @(posedge clk_sys) toggle_ovr_en <= 8'h00;
    rd(3'h1, 8'heb);
  endtask
  task automatic t_sleep;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    int_sense <= 16'hc270;
    ext_int_en <= 8'h01;
    in_enable_ovr_en <= 8'h12;
    in_enable_ovr_val <= 8'h02;
    repeat (3) @(posedge clk_sys);
    #1 check(alt_raw_input, 8'hef);
    @(posedge clk_sys) sleep_active <= 1'b1;
    #1 check(alt_raw_input, 8'h03);
    rd(3'h2, 8'h03);
    wr(3'h4, 8'hff);
    check(ext_int_flag, 8'h00);
    @(posedge clk_sys) sleep_active <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check(ext_int_flag, 8'h8c);
  endtask
  // ------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, port_write_strobe, port_read_strobe, sleep_active, addr, wdata} = '0;
    {int_sense, ext_int_en, pullup_ovr_en, pullup_ovr_val, drv_ovr_en, drv_ovr_val} = '0;
    {value_ovr_en, value_ovr_val, toggle_ovr_en, in_enable_ovr_en, in_enable_ovr_val} = '0;
    {ext_en, ext_val} = '0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_tristate();
    t_regs();
    t_pullup();
    t_drive();
    t_toggle();
    t_sleep();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    finish_test();
  end
endmodule // pps_port_tb_top
`default_nettype wire
